// ---- src/gate_consts.svh ----
// Constants for the privileged opcode gate: field positions, opcodes,
// library-call codes, register offsets and reset values.
// Included by every design file that needs a number; holds no logic.
`ifndef GATE_CONSTS_SVH
`define GATE_CONSTS_SVH

// ------------------------
// Instruction fields
// ------------------------
`define OPC_MSB 31
`define OPC_LSB 26
`define FUNC_MSB 25
`define FUNC_LSB 0
`define DREG_MSB 25
`define DREG_LSB 21
`define BREG_MSB 20
`define BREG_LSB 16
`define ATYPE_MSB 15
`define ATYPE_LSB 13
`define ALEN_BIT 12
`define BYTE_DISPLACEMENT_FIELD_MSB 11
`define BYTE_DISPLACEMENT_FIELD_LSB 0

// ------------------------
// Major opcodes
// ------------------------
`define OPC_CALL 6'h00
`define OPC_IREAD 6'h19
`define OPC_LOAD 6'h1B
`define OPC_IWRITE 6'h1D
`define OPC_RET 6'h1E
`define OPC_STORE 6'h1F

// ------------------------
// Library-call function codes and access types
// ------------------------
`define CALL_PRIV_A 26'h0000000
`define CALL_PRIV_B 26'h0000002
`define CALL_UNPRIV 26'h0000086
`define ATYPE_PHYS 3'h0
`define ATYPE_COND 3'h1
`define ATYPE_VPTE 3'h2

// ------------------------
// Register map
// ------------------------
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define CTRL_HWE_BIT 0
`define CTRL_RESET 1'h0
`define STATUS_MODE_BIT 0
`define STATUS_FETCH_BIT 1
`define STATUS_CNT_LSB 16
`define ILL_CNT_RESET 16'h0000

`endif

// ---- src/gate_pkg.sv ----
// Types shared by the privileged opcode gate and its helpers.
// Compiled before any module that imports it.
package gate_pkg;
   typedef enum logic [2:0] {
      ENTRY_NONE, ENTRY_RESET, ENTRY_MACHINE_CHECK, ENTRY_ARITHMETIC_TRAP,
      ENTRY_MM, ENTRY_ILLEGAL, ENTRY_IRQ, ENTRY_CALL
   } entry_kind_e;
   typedef enum logic [2:0] {
      OP_OTHER, OP_LOAD, OP_STORE, OP_RET, OP_IREAD, OP_IWRITE, OP_CALL
   } op_class_e;
endpackage

// ---- src/opcode_field_decode.sv ----
// Pure field decoder for one 32-bit instruction word.
// Assumes its caller registers whatever it passes on.
`timescale 1ns/1ns
`include "gate_consts.svh"
module opcode_field_decode (
   input wire logic [31:0] instr_i,
   output gate_pkg::op_class_e op_class_o,
   output logic call_priv_o,
   output logic call_known_o,
   output logic [25:0] call_func_o,
   output logic [2:0] access_type_o,
   output logic access_length_field_o,
   output logic [11:0] byte_displacement_field_o,
   output logic [4:0] base_reg_field_o,
   output logic [4:0] data_reg_field_o
);
   import gate_pkg::*;
   logic [5:0] opc;

   assign opc = instr_i[`OPC_MSB:`OPC_LSB];
   assign access_type_o = instr_i[`ATYPE_MSB:`ATYPE_LSB];
   assign access_length_field_o = instr_i[`ALEN_BIT];
   assign byte_displacement_field_o = instr_i[`BYTE_DISPLACEMENT_FIELD_MSB:`BYTE_DISPLACEMENT_FIELD_LSB];
   assign base_reg_field_o = instr_i[`BREG_MSB:`BREG_LSB];
   assign data_reg_field_o = instr_i[`DREG_MSB:`DREG_LSB];
   assign call_func_o = instr_i[`FUNC_MSB:`FUNC_LSB];
   assign call_priv_o = (call_func_o == `CALL_PRIV_A) ||
                        (call_func_o == `CALL_PRIV_B);
   assign call_known_o = call_priv_o || (call_func_o == `CALL_UNPRIV);

   // ------------------------
   // Opcode class
   // ------------------------
   always_comb begin
      unique case (opc)
         `OPC_LOAD: op_class_o = OP_LOAD;
         `OPC_STORE: op_class_o = OP_STORE;
         `OPC_RET: op_class_o = OP_RET;
         `OPC_IREAD: op_class_o = OP_IREAD;
         `OPC_IWRITE: op_class_o = OP_IWRITE;
         `OPC_CALL: op_class_o = OP_CALL;
         default: op_class_o = OP_OTHER;
      endcase
   end
endmodule

// ---- src/gate_wb_regs.sv ----
// Classic Wishbone slave with the control and status words of the gate.
// Assumes a master that holds its request until it sees ack.
`timescale 1ns/1ns
`include "gate_consts.svh"
module gate_wb_regs (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic priv_mode_i,
   input wire logic fetch_translate_i,
   input wire logic [15:0] ill_count_i,
   output logic kernel_hw_instr_enable_o
);
   import gate_pkg::*;
   logic req;

   // Ack drops the cycle after it rises, so one access per request
   assign req = cyc_i && stb_i && !ack_o;

   // ------------------------
   // Handshake and read data
   // ------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else if (ce_i) begin
         ack_o <= req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h00000000;
      end else if (ce_i && req) begin
         dat_o <= 32'h00000000;
         if (!we_i && adr_i == `REG_CTRL) begin
            dat_o[`CTRL_HWE_BIT] <= kernel_hw_instr_enable_o;
         end else if (!we_i && adr_i == `REG_STATUS) begin
            dat_o[`STATUS_MODE_BIT] <= priv_mode_i;
            dat_o[`STATUS_FETCH_BIT] <= fetch_translate_i;
            dat_o[`STATUS_CNT_LSB +: 16] <= ill_count_i;
         end
      end
   end

   // ------------------------
   // Control word
   // ------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         kernel_hw_instr_enable_o <= `CTRL_RESET;
      end else if (ce_i && req && we_i && adr_i == `REG_CTRL &&
                   sel_i[0]) begin
         kernel_hw_instr_enable_o <= dat_i[`CTRL_HWE_BIT];
      end
   end
endmodule

// ---- src/privileged_mode_opcode_gate.sv ----
// Privileged library mode tracker, opcode decoder and privilege gate.
// Assumes one instruction offered per cycle on instr_valid_i, event
// inputs as one-cycle pulses, and software on classic Wishbone.
`timescale 1ns/1ns
`include "gate_consts.svh"
module privileged_mode_opcode_gate #(
   parameter int PC_W = 64
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic instr_valid_i,
   input wire logic [31:0] instr_i,
   input wire logic kernel_mode_i,
   input wire logic [PC_W-1:0] base_reg_value_i,
   input wire logic lock_flag_i,
   input wire logic machine_check_i,
   input wire logic arithmetic_trap_i,
   input wire logic mm_fault_i,
   input wire logic irq_i,
   output logic priv_mode_o,
   output logic fetch_translate_o,
   output logic data_translate_o,
   output logic mm_bypass_o,
   output logic align_trap_suppress_o,
   output logic vpte_fetch_o,
   output logic store_cond_o,
   output logic lock_result_valid_o,
   output logic lock_result_o,
   output logic [4:0] lock_dest_reg_o,
   output logic op_valid_o,
   output gate_pkg::op_class_e op_class_o,
   output logic [2:0] access_type_o,
   output logic access_length_field_o,
   output logic [11:0] byte_displacement_field_o,
   output logic [4:0] base_reg_field_o,
   output logic [4:0] data_reg_field_o,
   output logic [25:0] call_func_o,
   output logic call_priv_o,
   output logic entry_valid_o,
   output gate_pkg::entry_kind_e entry_kind_o,
   output logic irq_ack_o,
   output logic redirect_valid_o,
   output logic [PC_W-1:0] redirect_pc_o
);
   import gate_pkg::*;

   // ------------------------
   // Elaboration check
   // ------------------------
   // Bit 0 of the base value is the mode, so the target needs more
   if (PC_W < 2) begin : g_bad_width
      $error("PC_W must be at least 2");
   end

   // ------------------------
   // Decode and register interface
   // ------------------------
   op_class_e dec_class;
   logic dec_call_priv;
   logic dec_call_known;
   logic [25:0] dec_func;
   logic [2:0] dec_type;
   logic dec_len;
   logic [11:0] dec_byte_displacement_field;
   logic [4:0] dec_breg;
   logic [4:0] dec_dreg;
   logic kernel_hw_instr_enable;
   logic [15:0] ill_count_reg;

   opcode_field_decode u_decode (
      .instr_i(instr_i),
      .op_class_o(dec_class),
      .call_priv_o(dec_call_priv),
      .call_known_o(dec_call_known),
      .call_func_o(dec_func),
      .access_type_o(dec_type),
      .access_length_field_o(dec_len),
      .byte_displacement_field_o(dec_byte_displacement_field),
      .base_reg_field_o(dec_breg),
      .data_reg_field_o(dec_dreg)
   );

   gate_wb_regs u_regs (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .cyc_i(cyc_i),
      .stb_i(stb_i),
      .we_i(we_i),
      .adr_i(adr_i),
      .sel_i(sel_i),
      .dat_i(dat_i),
      .dat_o(dat_o),
      .ack_o(ack_o),
      .priv_mode_i(priv_mode_o),
      .fetch_translate_i(fetch_translate_o),
      .ill_count_i(ill_count_reg),
      .kernel_hw_instr_enable_o(kernel_hw_instr_enable)
   );

   // ------------------------
   // Gating
   // ------------------------
   logic reserved_op;
   logic allowed;
   logic illegal;
   logic accepted;
   logic take_irq;
   logic any_entry;
   logic do_ret;
   logic is_load;
   logic is_store;
   logic phys_type;
   entry_kind_e kind_next;

   assign reserved_op = (dec_class == OP_LOAD) || (dec_class == OP_STORE) ||
                        (dec_class == OP_RET) || (dec_class == OP_IREAD) ||
                        (dec_class == OP_IWRITE);
   assign allowed = priv_mode_o || (kernel_mode_i && kernel_hw_instr_enable);
   // reserved opcode outside mode
   // Privileged calls from user mode are refused the same way
   assign illegal = instr_valid_i &&
                    ((reserved_op && !allowed) ||
                     (dec_class == OP_CALL && dec_call_priv &&
                      !priv_mode_o && !kernel_mode_i));
   assign accepted = instr_valid_i && reserved_op && allowed;
   assign take_irq = irq_i && !priv_mode_o;
   assign is_load = accepted && dec_class == OP_LOAD;
   assign is_store = accepted && dec_class == OP_STORE;
   assign phys_type = (dec_type == `ATYPE_PHYS) || (dec_type == `ATYPE_COND);

   always_comb begin
      if (machine_check_i) begin
         kind_next = ENTRY_MACHINE_CHECK;
      end else if (arithmetic_trap_i) begin
         kind_next = ENTRY_ARITHMETIC_TRAP;
      end else if (mm_fault_i) begin
         kind_next = ENTRY_MM;
      end else if (illegal) begin
         kind_next = ENTRY_ILLEGAL;
      end else if (take_irq) begin
         kind_next = ENTRY_IRQ;
      end else if (instr_valid_i && dec_class == OP_CALL &&
                   dec_call_known) begin
         kind_next = ENTRY_CALL;
      end else begin
         kind_next = ENTRY_NONE;
      end
   end

   assign any_entry = (kind_next != ENTRY_NONE);
   // An entry in the same cycle overrides a return
   assign do_ret = accepted && dec_class == OP_RET && !any_entry;

   // ------------------------
   // Mode bit and fetch mapping
   // ------------------------
   // single mode bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         priv_mode_o <= 1'b1;
      end else if (ce_i) begin
         if (any_entry) begin
            priv_mode_o <= 1'b1;
         end else if (do_ret) begin
            priv_mode_o <= base_reg_value_i[0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fetch_translate_o <= 1'b0;
      end else if (ce_i) begin
         if (any_entry) begin
            fetch_translate_o <= 1'b0;
         end else if (do_ret) begin
            fetch_translate_o <= !base_reg_value_i[0];
         end
      end
   end

   // ------------------------
   // Entries
   // ------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         entry_valid_o <= 1'b1;
         entry_kind_o <= ENTRY_RESET;
         irq_ack_o <= 1'b0;
      end else if (ce_i) begin
         entry_valid_o <= any_entry;
         entry_kind_o <= kind_next;
         irq_ack_o <= (kind_next == ENTRY_IRQ);
      end
   end

   // Counter saturates rather than wrapping to zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ill_count_reg <= `ILL_CNT_RESET;
      end else if (ce_i && kind_next == ENTRY_ILLEGAL &&
                   ill_count_reg != 16'hFFFF) begin
         ill_count_reg <= ill_count_reg + 16'h0001;
      end
   end

   // ------------------------
   // Memory path controls
   // ------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_translate_o <= 1'b1;
         mm_bypass_o <= 1'b0;
         align_trap_suppress_o <= 1'b0;
         vpte_fetch_o <= 1'b0;
      end else if (ce_i) begin
         // only physical privileged types skip mapping
         data_translate_o <= !((is_load || is_store) && phys_type);
         mm_bypass_o <= is_load || is_store;
         // no alignment trap for privileged access
         align_trap_suppress_o <= is_load || is_store;
         vpte_fetch_o <= is_load && dec_type == `ATYPE_VPTE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         store_cond_o <= 1'b0;
         lock_result_valid_o <= 1'b0;
         lock_result_o <= 1'b0;
         lock_dest_reg_o <= 5'h00;
      end else if (ce_i) begin
         store_cond_o <= is_store && dec_type == `ATYPE_COND;
         lock_result_valid_o <= is_store && dec_type == `ATYPE_COND;
         lock_result_o <= lock_flag_i;
         lock_dest_reg_o <= dec_dreg;
      end
   end

   // ------------------------
   // Decoded operation
   // ------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         op_valid_o <= 1'b0;
         op_class_o <= OP_OTHER;
         access_type_o <= 3'h0;
         access_length_field_o <= 1'b0;
         byte_displacement_field_o <= 12'h000;
         base_reg_field_o <= 5'h00;
         data_reg_field_o <= 5'h00;
         call_func_o <= 26'h0000000;
         call_priv_o <= 1'b0;
      end else if (ce_i) begin
         op_valid_o <= instr_valid_i && !illegal;
         op_class_o <= dec_class;
         // fields registered for the data path
         access_type_o <= dec_type;
         access_length_field_o <= dec_len;
         byte_displacement_field_o <= dec_byte_displacement_field;
         base_reg_field_o <= dec_breg;
         data_reg_field_o <= dec_dreg;
         call_func_o <= dec_func;
         call_priv_o <= dec_call_priv;
      end
   end

   // ------------------------
   // Return redirect
   // ------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         redirect_valid_o <= 1'b0;
         redirect_pc_o <= '0;
      end else if (ce_i) begin
         redirect_valid_o <= do_ret;
         redirect_pc_o <= {base_reg_value_i[PC_W-1:1], 1'b0};
      end
   end
endmodule

// ---- dv/gate_checker_asserts.sv ----
// Concurrent checks on the ports of the privileged opcode gate.
// Bound into the gate; one clock, synchronous active-high reset.
`timescale 1ns/1ns
module gate_checker #(
   parameter int PC_W = 64
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic instr_valid_i,
   input wire logic [31:0] instr_i,
   input wire logic kernel_mode_i,
   input wire logic [PC_W-1:0] base_reg_value_i,
   input wire logic lock_flag_i,
   input wire logic machine_check_i,
   input wire logic arithmetic_trap_i,
   input wire logic mm_fault_i,
   input wire logic irq_i,
   input wire logic priv_mode_o,
   input wire logic fetch_translate_o,
   input wire logic data_translate_o,
   input wire logic mm_bypass_o,
   input wire logic align_trap_suppress_o,
   input wire logic vpte_fetch_o,
   input wire logic store_cond_o,
   input wire logic lock_result_o,
   input wire logic op_valid_o,
   input wire logic [2:0] access_type_o,
   input wire logic [11:0] byte_displacement_field_o,
   input wire logic entry_valid_o,
   input gate_pkg::entry_kind_e entry_kind_o,
   input wire logic irq_ack_o,
   input wire logic redirect_valid_o,
   input wire logic [PC_W-1:0] redirect_pc_o
);
   import gate_pkg::*;
   // ------------------------
   // Helpers
   // ------------------------
   // Machine check, arithmetic trap and MM fault outrank decode, so decode checks need a cycle without them
   logic go;
   logic [5:0] opc;
   assign go = ce_i & instr_valid_i & ~machine_check_i & ~arithmetic_trap_i
      & ~mm_fault_i;
   assign opc = instr_i[31:26];
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ------------------------
   // Assertions
   // ------------------------
   fetch_map_a: assert property (fetch_translate_o == !priv_mode_o)
      else $error("fetch mapping disagrees with mode");
   irq_block_a: assert property (priv_mode_o && irq_i && ce_i |=>
      !irq_ack_o && !(entry_valid_o && entry_kind_o == ENTRY_IRQ))
      else $error("interrupt taken in library mode");
   reset_entry_a: assert property ($fell(rst_i) |-> priv_mode_o &&
      entry_valid_o && entry_kind_o == ENTRY_RESET)
      else $error("reset did not enter library mode");
   entry_mode_a: assert property (entry_valid_o |-> priv_mode_o)
      else $error("entry without library mode");
   illegal_a: assert property (go && !priv_mode_o && !kernel_mode_i &&
      opc inside {6'h19, 6'h1B, 6'h1D, 6'h1E, 6'h1F} |=> entry_valid_o &&
      entry_kind_o == ENTRY_ILLEGAL && !op_valid_o)
      else $error("reserved opcode not refused");
   return_a: assert property (go && priv_mode_o && opc == 6'h1E |=>
      redirect_valid_o && !redirect_pc_o[0] &&
      redirect_pc_o[PC_W-1:1] == $past(base_reg_value_i[PC_W-1:1]) &&
      priv_mode_o == $past(base_reg_value_i[0]))
      else $error("return target or mode wrong");
   pte_load_a: assert property (go && priv_mode_o &&
      opc == 6'h1B && instr_i[15:13] == 3'h2 |=> vpte_fetch_o &&
      mm_bypass_o && align_trap_suppress_o && data_translate_o)
      else $error("page-table load effects wrong");
   store_cond_a: assert property (go && priv_mode_o && opc == 6'h1F &&
      instr_i[15:13] == 3'h1 |=> store_cond_o &&
      lock_result_o == $past(lock_flag_i))
      else $error("conditional store result wrong");
   fields_a: assert property (ce_i && !rst_i |=>
      access_type_o == $past(instr_i[15:13]) &&
      byte_displacement_field_o == $past(instr_i[11:0]))
      else $error("load or store field decode wrong");
endmodule

bind privileged_mode_opcode_gate gate_checker #(.PC_W(PC_W)) gate_checker_i (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .instr_valid_i(instr_valid_i),
   .instr_i(instr_i), .kernel_mode_i(kernel_mode_i),
   .base_reg_value_i(base_reg_value_i), .lock_flag_i(lock_flag_i),
   .machine_check_i(machine_check_i), .arithmetic_trap_i(arithmetic_trap_i),
   .mm_fault_i(mm_fault_i), .irq_i(irq_i), .priv_mode_o(priv_mode_o),
   .fetch_translate_o(fetch_translate_o), .data_translate_o(data_translate_o),
   .mm_bypass_o(mm_bypass_o), .align_trap_suppress_o(align_trap_suppress_o),
   .vpte_fetch_o(vpte_fetch_o), .store_cond_o(store_cond_o),
   .lock_result_o(lock_result_o), .op_valid_o(op_valid_o),
   .access_type_o(access_type_o),
   .byte_displacement_field_o(byte_displacement_field_o),
   .entry_valid_o(entry_valid_o), .entry_kind_o(entry_kind_o),
   .irq_ack_o(irq_ack_o), .redirect_valid_o(redirect_valid_o),
   .redirect_pc_o(redirect_pc_o));

// ---- dv/tb.sv ----
// Self-checking bench for the privileged opcode gate: instruction and
// event table, then bus, reset and library-mode cases.
// Assumes package, constants header and checker are compiled first.
`timescale 1ns/1ns
module tb;
   import gate_pkg::*;
   // Flags are {valid, kernel, hw enable, entry, op valid}
   typedef struct {
      logic [4:0] f;
      logic [31:0] ins;
      logic [3:0] ev;
      entry_kind_e kind;
      op_class_e cls;
   } row_s;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [3:0] adr_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic instr_valid_i = 1'b0;
   logic [31:0] instr_i = 32'h0;
   logic kernel_mode_i = 1'b0;
   logic [63:0] base_reg_value_i = 64'h0;
   logic lock_flag_i = 1'b0;
   logic [3:0] ev = 4'h0;
   logic [31:0] dat_o, q;
   logic ack_o, priv_mode_o, fetch_translate_o, data_translate_o;
   logic mm_bypass_o, align_trap_suppress_o, vpte_fetch_o, store_cond_o;
   logic lock_result_valid_o, lock_result_o, op_valid_o, access_length_field_o;
   logic entry_valid_o, irq_ack_o, redirect_valid_o, call_priv_o;
   logic [4:0] lock_dest_reg_o, base_reg_field_o, data_reg_field_o;
   logic [25:0] call_func_o;
   logic [2:0] access_type_o;
   logic [11:0] byte_displacement_field_o;
   logic [63:0] redirect_pc_o;
   op_class_e op_class_o;
   entry_kind_e entry_kind_o;
   int n_mismatch = 0;
   int checks = 0;
   int n_ill = 0;
   row_s rows[19] = '{
      '{5'b10010, 32'h6C000000, 4'h0, ENTRY_ILLEGAL, OP_LOAD},
      '{5'b10010, 32'h7C000000, 4'h0, ENTRY_ILLEGAL, OP_STORE},
      '{5'b10010, 32'h78000000, 4'h0, ENTRY_ILLEGAL, OP_RET},
      '{5'b10010, 32'h64000000, 4'h0, ENTRY_ILLEGAL, OP_IREAD},
      '{5'b10010, 32'h74000000, 4'h0, ENTRY_ILLEGAL, OP_IWRITE},
      '{5'b11010, 32'h6C000000, 4'h0, ENTRY_ILLEGAL, OP_LOAD},
      '{5'b11101, 32'h6C000000, 4'h0, ENTRY_NONE, OP_LOAD},
      '{5'b11101, 32'h74000000, 4'h0, ENTRY_NONE, OP_IWRITE},
      '{5'b10011, 32'h00000086, 4'h0, ENTRY_CALL, OP_CALL},
      '{5'b10010, 32'h00000000, 4'h0, ENTRY_ILLEGAL, OP_CALL},
      '{5'b10010, 32'h00000002, 4'h0, ENTRY_ILLEGAL, OP_CALL},
      '{5'b11011, 32'h00000002, 4'h0, ENTRY_CALL, OP_CALL},
      '{5'b10001, 32'h40000000, 4'h0, ENTRY_NONE, OP_OTHER},
      '{5'b00010, 32'h00000000, 4'h8, ENTRY_MACHINE_CHECK, OP_OTHER},
      '{5'b00010, 32'h00000000, 4'h4, ENTRY_ARITHMETIC_TRAP, OP_OTHER},
      '{5'b00010, 32'h00000000, 4'h2, ENTRY_MM, OP_OTHER},
      '{5'b00010, 32'h00000000, 4'h1, ENTRY_IRQ, OP_OTHER},
      '{5'b00010, 32'h00000000, 4'hF, ENTRY_MACHINE_CHECK, OP_OTHER},
      '{5'b10010, 32'h6C000000, 4'h1, ENTRY_ILLEGAL, OP_LOAD}};

   always #5 clk_i = ~clk_i;

   privileged_mode_opcode_gate #(.PC_W(64)) privileged_mode_opcode_gate_i (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .instr_valid_i(instr_valid_i), .instr_i(instr_i),
      .kernel_mode_i(kernel_mode_i), .base_reg_value_i(base_reg_value_i),
      .lock_flag_i(lock_flag_i), .machine_check_i(ev[3]),
      .arithmetic_trap_i(ev[2]), .mm_fault_i(ev[1]), .irq_i(ev[0]),
      .priv_mode_o(priv_mode_o), .fetch_translate_o(fetch_translate_o),
      .data_translate_o(data_translate_o), .mm_bypass_o(mm_bypass_o),
      .align_trap_suppress_o(align_trap_suppress_o),
      .vpte_fetch_o(vpte_fetch_o), .store_cond_o(store_cond_o),
      .lock_result_valid_o(lock_result_valid_o),
      .lock_result_o(lock_result_o), .lock_dest_reg_o(lock_dest_reg_o),
      .op_valid_o(op_valid_o), .op_class_o(op_class_o),
      .access_type_o(access_type_o),
      .access_length_field_o(access_length_field_o),
      .byte_displacement_field_o(byte_displacement_field_o),
      .base_reg_field_o(base_reg_field_o), .data_reg_field_o(data_reg_field_o),
      .call_func_o(call_func_o), .call_priv_o(call_priv_o),
      .entry_valid_o(entry_valid_o), .entry_kind_o(entry_kind_o),
      .irq_ack_o(irq_ack_o),
      .redirect_valid_o(redirect_valid_o), .redirect_pc_o(redirect_pc_o));

   // ------------------------
   // Tasks
   // ------------------------
   task automatic chk(input string what, input logic [79:0] seen,
      input logic [79:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // Data taken at the edge that samples ack; watchdog ends a hang
   task automatic wb(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      r = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask

   // One instruction or event cycle; outputs looked at one edge later
   task automatic step(input logic iv, input logic [31:0] ins,
      input logic km, input logic [3:0] e, input logic [63:0] base,
      input logic lk);
      @(posedge clk_i);
      instr_valid_i <= iv;
      instr_i <= ins;
      kernel_mode_i <= km;
      ev <= e;
      base_reg_value_i <= base;
      lock_flag_i <= lk;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      ev <= 4'h0;
      #1;
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      #100000;
      n_mismatch++;
      wrap_up();
   end

   // ------------------------
   // Sequence
   // ------------------------
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      step(1'b1, 32'h78000000, 1'b0, 4'h0, 64'h0, 1'b0);
      for (int k = 0; k < 19; k++) begin
         wb(1'b1, 4'h0, {31'h0, rows[k].f[2]}, q);
         step(rows[k].f[4], rows[k].ins, rows[k].f[3], rows[k].ev, 64'h0,
            1'b0);
         chk("entry", entry_valid_o, rows[k].f[1]);
         if (rows[k].f[1]) chk("kind", entry_kind_o, rows[k].kind);
         chk("mode", priv_mode_o, rows[k].f[1]);
         chk("op valid", op_valid_o, rows[k].f[0]);
         chk("irq ack", irq_ack_o, rows[k].kind == ENTRY_IRQ);
         if (rows[k].f[4]) chk("class", op_class_o, rows[k].cls);
         if (rows[k].cls == OP_CALL) chk("call", {call_priv_o, call_func_o},
            {rows[k].ins[7:0] != 8'h86, rows[k].ins[25:0]});
         if (rows[k].kind == ENTRY_ILLEGAL) n_ill++;
         if (priv_mode_o === 1'b1) begin
            step(1'b1, 32'h78000000, 1'b0, 4'h0, 64'h0, 1'b0);
         end
      end
      wb(1'b0, 4'h4, 32'h0, q);
      chk("ill count", q[31:16], n_ill);
      chk("status", q[1:0], 2'h2);
      $display("test table done");
      wb(1'b1, 4'h0, 32'hFFFFFFFF, q);
      wb(1'b0, 4'h0, 32'h0, q);
      chk("ctrl", q, 32'h00000001);
      wb(1'b1, 4'h8, 32'hFFFFFFFF, q);
      wb(1'b0, 4'h8, 32'h0, q);
      chk("unmapped", q, 32'h00000000);
      $display("test bus done");
      // Second reset mid-run, with the enable bit set
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk("rst kind", {entry_valid_o, entry_kind_o}, {1'b1, ENTRY_RESET});
      chk("rst maps", {priv_mode_o, fetch_translate_o, data_translate_o},
         3'h5);
      wb(1'b1, 4'h4, 32'hFFFFFFFF, q);
      wb(1'b0, 4'h4, 32'h0, q);
      chk("rst status", q, 32'h00000001);
      wb(1'b0, 4'h0, 32'h0, q);
      chk("rst ctrl", q, 32'h00000000);
      $display("test reset done");
      // Page-table load with an interrupt pending in library mode
      step(1'b1, {6'h1B, 5'd3, 5'd7, 3'h2, 1'b1, 12'hFFC}, 1'b0, 4'h1,
         64'h0, 1'b0);
      chk("load", {vpte_fetch_o, mm_bypass_o, align_trap_suppress_o,
         data_translate_o}, 4'hF);
      chk("irq held", {entry_valid_o, irq_ack_o}, 2'h0);
      chk("fields", {access_type_o, access_length_field_o,
         byte_displacement_field_o, base_reg_field_o, data_reg_field_o},
         {3'h2, 1'b1, 12'hFFC, 5'h07, 5'h03});
      step(1'b1, {6'h1F, 5'd5, 5'd0, 3'h1, 1'b0, 12'h0}, 1'b0, 4'h0,
         64'h0, 1'b1);
      chk("store", {store_cond_o, lock_result_valid_o, lock_result_o,
         lock_dest_reg_o}, {3'h7, 5'd5});
      step(1'b1, 32'h78000000, 1'b0, 4'h0, 64'h1001, 1'b0);
      chk("ret stay", {redirect_valid_o, priv_mode_o, redirect_pc_o},
         {2'h3, 64'h1000});
      step(1'b1, 32'h78000000, 1'b0, 4'h0, 64'h2000, 1'b0);
      chk("ret leave", {redirect_valid_o, priv_mode_o, fetch_translate_o,
         redirect_pc_o}, {3'h5, 64'h2000});
      // Enable low freezes state, so no entry and no new class
      @(posedge clk_i);
      ce_i <= 1'b0;
      step(1'b1, 32'h6C000000, 1'b0, 4'h1, 64'h0, 1'b0);
      chk("frozen", {entry_valid_o, priv_mode_o, op_class_o},
         {2'h0, OP_RET});
      $display("test library mode done");
      wrap_up();
   end
endmodule
